// File: common/eeprom_pkg.sv
`default_nettype none

package eeprom_pkg;

    localparam logic [5:0] OFS_CONTROL = 6'h1C;
    localparam logic [5:0] OFS_DATA    = 6'h1D;
    localparam logic [5:0] OFS_ADDR    = 6'h1E;

    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_START_BUSY  = 1;
    localparam int BIT_MASTER_EN   = 2;
    localparam int BIT_READY_IE    = 3;
    localparam int BIT_MODE_LO     = 4;
    localparam int BIT_MODE_HI     = 5;

    localparam int ADDR_W  = 6;
    localparam int DATA_W  = 8;
    localparam int DEPTH   = 64;

    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    localparam real CLK_MHZ      = 20.0;
    localparam real T_ATOMIC_MS  = 3.4;
    localparam real T_SPLIT_MS   = 1.8;
    localparam int  ATOMIC_CYCLES_DEF = int'(T_ATOMIC_MS * 1000.0 * CLK_MHZ);
    localparam int  SPLIT_CYCLES_DEF  = int'(T_SPLIT_MS * 1000.0 * CLK_MHZ);

    localparam logic [2:0] ARM_WINDOW   = 3'h4;
    localparam logic [2:0] START_STALL  = 3'h2;
    localparam logic [2:0] READ_STALL   = 3'h4;

    typedef enum logic [1:0] {
        MODE_ATOMIC = 2'b00,
        MODE_ERASE  = 2'b01,
        MODE_WRITE  = 2'b10,
        MODE_RSVD   = 2'b11
    } prog_mode_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_PROG = 2'b10
    } eng_state_t;

endpackage

`default_nettype wire

// File: hw/eeprom_access_control.sv
`default_nettype none

module eeprom_access_control
    import eeprom_pkg::*;
#(
    parameter int ATOMIC_CYCLES = ATOMIC_CYCLES_DEF,
    parameter int SPLIT_CYCLES  = SPLIT_CYCLES_DEF
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       por_n,
    input  wire logic [5:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_we,
    input  wire logic       io_re,
    input  wire logic       global_irq_enable,
    output logic      [7:0] io_rdata,
    output logic            cpu_stall,
    output logic            ready_irq
);

    localparam int TIMER_W = $clog2(ATOMIC_CYCLES + 1);

    if (ATOMIC_CYCLES < 1 || SPLIT_CYCLES < 1 || SPLIT_CYCLES > ATOMIC_CYCLES) begin
        $error("programming cycle counts out of range");
    end

    // decoded cpu accesses
    logic ctrl_wr;
    logic addr_wr;
    logic data_wr;
    logic start_req;
    logic start_ok;
    logic read_ok;

    // cpu-side state, reset by nrst
    logic [5:0] eeprom_addr_reg,  eeprom_addr_next;
    logic [7:0] eeprom_data_reg,  eeprom_data_next;
    logic       ready_irq_enable_reg, ready_irq_enable_next;
    logic       master_program_enable_reg, master_program_enable_next;
    logic [2:0] arm_cnt_reg,      arm_cnt_next;
    logic       read_strobe_reg,  read_strobe_next;
    logic [2:0] stall_cnt_reg,    stall_cnt_next;
    logic       cpu_stall_reg,    cpu_stall_next;
    logic       ready_irq_reg,    ready_irq_next;
    logic [7:0] io_rdata_reg,     io_rdata_next;

    // programming engine, reset at power-on; nrst also clears prog_mode_reg while idle
    eng_state_t       state_reg,     state_next;
    prog_mode_t       prog_mode_reg, prog_mode_next;
    prog_mode_t       op_mode_reg,   op_mode_next;
    logic [5:0]       op_addr_reg,   op_addr_next;
    logic [7:0]       op_data_reg,   op_data_next;
    logic [TIMER_W-1:0] timer_reg,   timer_next;
    logic             commit;
    logic [7:0]       commit_data;
    logic             program_start_busy;
    logic [7:0]       mem_rdata;

    assign program_start_busy = (state_reg == ENG_PROG);

    assign ctrl_wr   = io_we && (io_addr == OFS_CONTROL);
    assign addr_wr   = io_we && (io_addr == OFS_ADDR);
    assign data_wr   = io_we && (io_addr == OFS_DATA);
    assign start_req = ctrl_wr && io_wdata[BIT_START_BUSY];
    assign start_ok  = start_req && master_program_enable_reg && !program_start_busy
                       && (prog_mode_reg != MODE_RSVD);
    assign read_ok   = ctrl_wr && io_wdata[BIT_READ_STROBE] && !program_start_busy;

    always_comb begin
        eeprom_addr_next           = eeprom_addr_reg;
        eeprom_data_next           = eeprom_data_reg;
        ready_irq_enable_next      = ready_irq_enable_reg;
        master_program_enable_next = master_program_enable_reg;
        arm_cnt_next               = arm_cnt_reg;
        read_strobe_next           = 1'b0;
        stall_cnt_next             = stall_cnt_reg;
        io_rdata_next              = io_rdata_reg;

        if (addr_wr && !program_start_busy) begin
            eeprom_addr_next = io_wdata[5:0];
        end
        if (data_wr) begin
            eeprom_data_next = io_wdata;
        end
        if (read_strobe_reg) begin
            eeprom_data_next = mem_rdata;
        end
        if (ctrl_wr) begin
            ready_irq_enable_next = io_wdata[BIT_READY_IE];
        end

        // arming window counts down and drops the enable
        if (arm_cnt_reg != 3'h0) begin
            arm_cnt_next = arm_cnt_reg - 3'h1;
            if (arm_cnt_reg == 3'h1) begin
                master_program_enable_next = 1'b0;
            end
        end
        if (ctrl_wr && io_wdata[BIT_MASTER_EN]) begin
            master_program_enable_next = 1'b1;
            arm_cnt_next               = ARM_WINDOW;
        end

        if (read_ok) begin
            read_strobe_next = 1'b1;
        end

        if (stall_cnt_reg != 3'h0) begin
            stall_cnt_next = stall_cnt_reg - 3'h1;
        end
        if (start_ok) begin
            stall_cnt_next = START_STALL;
        end else if (read_ok) begin
            stall_cnt_next = READ_STALL;
        end
        cpu_stall_next = (stall_cnt_next != 3'h0);

        ready_irq_next = ready_irq_enable_reg && global_irq_enable && !program_start_busy;

        if (io_re) begin
            case (io_addr)
                OFS_CONTROL: io_rdata_next = {2'b00, prog_mode_reg, ready_irq_enable_reg,
                                              master_program_enable_reg, program_start_busy,
                                              read_strobe_reg};
                OFS_DATA:    io_rdata_next = eeprom_data_reg;
                OFS_ADDR:    io_rdata_next = {2'b00, eeprom_addr_reg};
                default:     io_rdata_next = RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            eeprom_addr_reg           <= 6'h00;
            eeprom_data_reg           <= 8'h00;
            ready_irq_enable_reg      <= 1'b0;
            master_program_enable_reg <= 1'b0;
            arm_cnt_reg               <= 3'h0;
            read_strobe_reg           <= 1'b0;
            stall_cnt_reg             <= 3'h0;
            cpu_stall_reg             <= 1'b0;
            ready_irq_reg             <= 1'b0;
            io_rdata_reg              <= RDATA_RESET;
        end else begin
            eeprom_addr_reg           <= eeprom_addr_next;
            eeprom_data_reg           <= eeprom_data_next;
            ready_irq_enable_reg      <= ready_irq_enable_next;
            master_program_enable_reg <= master_program_enable_next;
            arm_cnt_reg               <= arm_cnt_next;
            read_strobe_reg           <= read_strobe_next;
            stall_cnt_reg             <= stall_cnt_next;
            cpu_stall_reg             <= cpu_stall_next;
            ready_irq_reg             <= ready_irq_next;
            io_rdata_reg              <= io_rdata_next;
        end
    end

    always_comb begin
        state_next     = state_reg;
        prog_mode_next = prog_mode_reg;
        op_mode_next   = op_mode_reg;
        op_addr_next   = op_addr_reg;
        op_data_next   = op_data_reg;
        timer_next     = timer_reg;
        commit         = 1'b0;

        if (ctrl_wr && !program_start_busy) begin
            prog_mode_next = prog_mode_t'(io_wdata[BIT_MODE_HI:BIT_MODE_LO]);
        end
        if (!nrst && !program_start_busy) begin
            prog_mode_next = MODE_ATOMIC;
        end

        case (state_reg)
            ENG_IDLE: begin
                if (start_ok && nrst) begin
                    state_next   = ENG_PROG;
                    op_mode_next = prog_mode_reg;
                    op_addr_next = eeprom_addr_reg;
                    op_data_next = eeprom_data_reg;
                    if (prog_mode_reg == MODE_ATOMIC) begin
                        timer_next = TIMER_W'(ATOMIC_CYCLES - 1);
                    end else begin
                        timer_next = TIMER_W'(SPLIT_CYCLES - 1);
                    end
                end
            end
            ENG_PROG: begin
                // runs on through a cpu reset
                if (timer_reg == '0) begin
                    state_next = ENG_IDLE;
                    commit     = 1'b1;
                end else begin
                    timer_next = timer_reg - TIMER_W'(1);
                end
            end
            default: begin
                state_next = ENG_IDLE;
            end
        endcase
    end

    // write-only stores the byte as is; no erase check
    assign commit_data = (op_mode_reg == MODE_ERASE) ? ERASED_BYTE : op_data_reg;

    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            state_reg     <= ENG_IDLE;
            prog_mode_reg <= MODE_ATOMIC;
            op_mode_reg   <= MODE_ATOMIC;
            op_addr_reg   <= 6'h00;
            op_data_reg   <= 8'h00;
            timer_reg     <= '0;
        end else begin
            state_reg     <= state_next;
            prog_mode_reg <= prog_mode_next;
            op_mode_reg   <= op_mode_next;
            op_addr_reg   <= op_addr_next;
            op_data_reg   <= op_data_next;
            timer_reg     <= timer_next;
        end
    end

    eeprom_array #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_array (
        .mclk    (mclk),
        .wr_en   (commit),
        .wr_addr (op_addr_reg),
        .wr_data (commit_data),
        .rd_addr (eeprom_addr_reg),
        .rd_data (mem_rdata)
    );

    assign io_rdata  = io_rdata_reg;
    assign cpu_stall = cpu_stall_reg;
    assign ready_irq = ready_irq_reg;

    // assertion helpers
    logic [TIMER_W:0] busy_len_reg;
    logic [TIMER_W:0] exp_len;
    logic             arm_wr;

    assign arm_wr  = ctrl_wr && io_wdata[BIT_MASTER_EN];
    assign exp_len = (op_mode_reg == MODE_ATOMIC) ? (TIMER_W + 1)'(ATOMIC_CYCLES) : (TIMER_W + 1)'(SPLIT_CYCLES);

    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            busy_len_reg <= '0;
        end else begin
            busy_len_reg <= program_start_busy ? busy_len_reg + (TIMER_W + 1)'(1) : '0;
        end
    end

    sequence s_stall2;
        cpu_stall_reg [*2] ##1 !cpu_stall_reg;
    endsequence

    sequence s_stall4;
        cpu_stall_reg [*4] ##1 !cpu_stall_reg;
    endsequence

    property p_top_zero;
        @(posedge mclk) disable iff (!nrst)
        io_re && (io_addr == OFS_CONTROL || io_addr == OFS_ADDR) |=> io_rdata[7:6] == 2'b00;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("reserved top bits read nonzero");

    property p_prog_len;
        @(posedge mclk) disable iff (!por_n)
        $fell(program_start_busy) |-> busy_len_reg == exp_len;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming time wrong for mode");

    property p_mode_hold;
        @(posedge mclk) disable iff (!por_n || !nrst)
        program_start_busy && ctrl_wr |=> $stable(prog_mode_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy");

    property p_mode_reset;
        @(posedge mclk) disable iff (!por_n)
        !nrst && !program_start_busy |=> prog_mode_reg == MODE_ATOMIC;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared by reset");

    property p_irq_level;
        @(posedge mclk) disable iff (!nrst || !por_n)
        ##1 ready_irq_reg == $past(ready_irq_enable_reg && global_irq_enable && !program_start_busy);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("ready irq level wrong");

    property p_no_arm;
        @(posedge mclk) disable iff (!nrst || !por_n)
        start_req && !master_program_enable_reg && !program_start_busy |=> !program_start_busy;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("start without arming took effect");

    property p_arm_life;
        @(posedge mclk) disable iff (!nrst)
        arm_wr |=> master_program_enable_reg [*4] ##1 (!master_program_enable_reg || $past(arm_wr)
            || $past(arm_wr, 2) || $past(arm_wr, 3) || $past(arm_wr, 4));
    endproperty
    a_arm_life: assert property (p_arm_life) else $error("arming bit lifetime wrong");

    property p_start_stall;
        @(posedge mclk) disable iff (!nrst || !por_n)
        start_ok |=> program_start_busy ##0 s_stall2;
    endproperty
    a_start_stall: assert property (p_start_stall) else $error("start stall not two cycles");

    property p_read_stall;
        @(posedge mclk) disable iff (!nrst)
        read_ok |=> s_stall4;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

    property p_read_data;
        @(posedge mclk) disable iff (!nrst)
        read_ok |=> read_strobe_reg ##1 (!read_strobe_reg && eeprom_data_reg == $past(mem_rdata));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not captured");

    property p_addr_lock;
        @(posedge mclk) disable iff (!nrst || !por_n)
        program_start_busy && addr_wr |=> $stable(eeprom_addr_reg);
    endproperty
    a_addr_lock: assert property (p_addr_lock) else $error("address changed while busy");

endmodule

`default_nettype wire

// File: hw/eeprom_array.sv
`default_nettype none

module eeprom_array #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    input  wire logic          mclk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        rd_data <= cells[rd_addr];
    end

endmodule

`default_nettype wire

// File: test/eeprom_access_control_tb_top.sv
`default_nettype none

module eeprom_access_control_tb_top;
    import eeprom_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int AT_CYC = 40;
    localparam int SP_CYC = 20;

    logic       mclk;
    logic       nrst;
    logic       por_n;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic       io_we;
    logic       io_re;
    logic       global_irq_enable;
    logic [7:0] io_rdata;
    logic       cpu_stall;
    logic       ready_irq;
    int         miscompares;
    int         cmp_count;
    int         cyc;
    int         t0;
    int         n;
    int         k;
    logic [7:0] v;
    logic [7:0] d;
    logic [5:0] a;

    eeprom_access_control #(
        .ATOMIC_CYCLES(AT_CYC),
        .SPLIT_CYCLES (SP_CYC)
    ) eeprom_access_control_inst (
        .mclk             (mclk),
        .nrst             (nrst),
        .por_n            (por_n),
        .io_addr          (io_addr),
        .io_wdata         (io_wdata),
        .io_we            (io_we),
        .io_re            (io_re),
        .global_irq_enable(global_irq_enable),
        .io_rdata         (io_rdata),
        .cpu_stall        (cpu_stall),
        .ready_irq        (ready_irq)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) cyc <= cyc + 1;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
        @(posedge mclk);
        io_addr  <= ad;
        io_wdata <= dt;
        io_we    <= 1'b1;
        @(posedge mclk);
        io_we <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] ad, output logic [7:0] dt);
        @(posedge mclk);
        io_addr <= ad;
        io_re   <= 1'b1;
        @(posedge mclk);
        io_re <= 1'b0;
        #1;
        dt = io_rdata;
    endtask

    // counts stall cycles following the write just taken
    task automatic stallcnt(output int cnt);
        cnt = 0;
        #1;
        repeat (8) begin
            if (cpu_stall === 1'b1) cnt++;
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic prog(input logic [5:0] ad, input logic [7:0] dt, input prog_mode_t m);
        int c;
        wr(OFS_ADDR, {2'b00, ad});
        wr(OFS_DATA, dt);
        wr(OFS_CONTROL, {2'b00, m, 4'hC});
        wr(OFS_CONTROL, {2'b00, m, 4'hE});
        t0 = cyc;
        stallcnt(c);
        chk8(8'(c), 8'h02);
        rd(OFS_CONTROL, v);
        chk8(v, {2'b00, m, 4'hA});
    endtask

    task automatic finish(input int dur, input logic irq_exp);
        int i;
        i = 0;
        v = 8'h02;
        while (v[1] !== 1'b0 && i < 200) begin
            rd(OFS_CONTROL, v);
            i++;
        end
        chk8({7'h00, (cyc - t0 >= dur) && (cyc - t0 <= dur + 8)}, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk8({7'h00, ready_irq}, {7'h00, irq_exp});
    endtask

    task automatic check_read(input logic [5:0] ad, input logic [7:0] exp);
        int c;
        wr(OFS_ADDR, {2'b00, ad});
        wr(OFS_CONTROL, 8'h09);
        stallcnt(c);
        chk8(8'(c), 8'h04);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h08);
        rd(OFS_DATA, v);
        chk8(v, exp);
    endtask

    task automatic busy_refusals(input logic [5:0] ad);
        int c;
        wr(OFS_CONTROL, 8'h38);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h0A);
        wr(OFS_ADDR, {2'b00, ~ad});
        rd(OFS_ADDR, v);
        chk8(v, {2'b00, ad});
        wr(OFS_CONTROL, 8'h09);
        stallcnt(c);
        chk8(8'(c), 8'h00);
        chk8({7'h00, ready_irq}, 8'h00);
    endtask

    task automatic pulse_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
    endtask

    initial begin
        cyc = 0;
        miscompares = 0;
        cmp_count = 0;
        nrst = 1'b0;
        por_n = 1'b0;
        io_addr = 6'h00;
        io_wdata = 8'h00;
        io_we = 1'b0;
        io_re = 1'b0;
        global_irq_enable = 1'b0;
        void'($urandom(22704));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        rd(OFS_CONTROL, v);
        chk8(v, 8'h00);
        rd(OFS_ADDR, v);
        chk8(v, 8'h00);
        rd(6'h05, v);
        chk8(v, 8'h00);
        wr(OFS_ADDR, 8'hFF);
        rd(OFS_ADDR, v);
        chk8(v, 8'h3F);
        wr(OFS_CONTROL, 8'hC8);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h08);
        repeat (2) @(posedge mclk);
        #1;
        chk8({7'h00, ready_irq}, 8'h00);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk8({7'h00, ready_irq}, 8'h01);
        wr(OFS_CONTROL, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        chk8({7'h00, ready_irq}, 8'h00);
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            a = (k == 0) ? 6'h3F : (k == 1) ? 6'h00 : 6'($urandom_range(63));
            d = 8'($urandom);
            prog(a, d, MODE_ATOMIC);
            if (k == 0) busy_refusals(a);
            finish(AT_CYC, 1'b1);
            check_read(a, d);
            prog(a, 8'h00, MODE_ERASE);
            finish(SP_CYC, 1'b1);
            check_read(a, ERASED_BYTE);
            d = 8'($urandom);
            prog(a, d, MODE_WRITE);
            finish(SP_CYC, 1'b1);
            check_read(a, d);
        end
        $display("test programming done");
        wr(OFS_CONTROL, 8'h0A);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h08);
        wr(OFS_CONTROL, 8'h0C);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h0C);
        repeat (6) @(posedge mclk);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h08);
        wr(OFS_CONTROL, 8'h0E);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h0C);
        wr(OFS_CONTROL, 8'h3C);
        wr(OFS_CONTROL, 8'h3E);
        repeat (6) @(posedge mclk);
        rd(OFS_CONTROL, v);
        chk8(v, 8'h38);
        $display("test refusals done");
        prog(6'h15, 8'h5A, MODE_ATOMIC);
        finish(AT_CYC, 1'b1);
        prog(6'h15, 8'h00, MODE_ERASE);
        pulse_reset();
        rd(OFS_CONTROL, v);
        chk8(v, 8'h12);
        finish(SP_CYC, 1'b0);
        check_read(6'h15, ERASED_BYTE);
        wr(OFS_CONTROL, 8'h20);
        pulse_reset();
        rd(OFS_CONTROL, v);
        chk8(v, 8'h00);
        $display("test reset done");
        results();
    end

    initial begin
        repeat (6000) @(posedge mclk);
        miscompares++;
        results();
    end

endmodule

`default_nettype wire
